/* hw/gimbal_cmd_pkg.sv */
// Purpose: Constants, types and register map for the gimbal command interface.
// Assumes: 25 MHz single clock, APB register access, 16-bit command words.
// Notes: Long cycle counts are also exposed as top-level parameters.
// Summary of operation
// - Load needles at start and every half second with current error values.
// - Refresh pitch and yaw error sources once per 40 or 80 ms sample.
// - Scale needle values so full deflection equals 16-7/8 degrees.
// - Issue only the change of each command since the previous sample.
// - Increments go to output counters and leave as 3200 pps pulse trains.
// - One command bit equals 0.0237 degree of engine deflection.
// - Gimbal drive enable alone energizes the relays; panel switch only arms.
// - Assert the error counter enable so the converter tracks increments.
// - Pending increments leave only while the release bits are set.
// - A restart clears drive enable and the error counter enable.
// - After restart restore discretes and reload counters with previous commands.
// - Results go to temporary storage, then a copy phase; restart repeats copy.
// - Restart in computation chooses redoing the section or the whole cycle.
// - After restore wait one more sample period before new increments.
// - Stroke starts at once in 80 ms mode, else 4 s after switchover.
// - Stroke pulse added to pitch every 20 ms; yaw never stroked.
// - Stroke table holds frequency count four plus two words per frequency.
// - Half-amplitude pulses are 10, 6, 5, 4, alternating sign as a triangle.
// - Stroke pulse amplitude equals the loaded stroke size in command bits.
// - Restart aborts the stroke test; a new request is needed.
// - Needle errors are commanded minus measured; full register is 180 degrees.
package gimbal_cmd_pkg;
  localparam int CLOCK_HZ = 25_000_000;
  localparam int TICK_MS = 20;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam int PULSE_PPS = 3200;
  localparam int PULSE_CYCLES = CLOCK_HZ / PULSE_PPS;
  localparam int SAMPLE_FAST_MS = 40;
  localparam int SAMPLE_SLOW_MS = 80;
  localparam logic [2:0] SAMPLE_FAST_TICKS = 3'(SAMPLE_FAST_MS / TICK_MS);
  localparam logic [2:0] SAMPLE_SLOW_TICKS = 3'(SAMPLE_SLOW_MS / TICK_MS);
  localparam int NEEDLE_MS = 500;
  localparam logic [4:0] NEEDLE_TICKS = 5'(NEEDLE_MS / TICK_MS);
  localparam int STROKE_DELAY_MS = 4000;
  localparam logic [7:0] STROKE_DELAY_TICKS = 8'(STROKE_DELAY_MS / TICK_MS);
  localparam int REG_FULL_MILLIDEG = 180000;
  localparam int NEEDLE_FULL_MILLIDEG = 16875;
  localparam int CMD_LSB_MICRODEG = 23700;
  localparam int CONV_LSB_CENTIARCSEC = 8541;
  localparam logic [2:0] STROKE_FREQS = 3'h4;
  localparam logic [7:0] STROKE_HALF_AMP [4] = '{8'h0A, 8'h06, 8'h05, 8'h04};
  localparam logic [7:0] STROKE_REVERSALS [4] = '{8'h04, 8'h04, 8'h04, 8'h04};
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PITCH_CMD = 8'h04;
  localparam logic [7:0] OFF_YAW_CMD = 8'h08;
  localparam logic [7:0] OFF_PITCH_ATT = 8'h0C;
  localparam logic [7:0] OFF_YAW_ATT = 8'h10;
  localparam logic [7:0] OFF_ROLL_ATT = 8'h14;
  localparam logic [7:0] OFF_STROKE_SIZE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_COUNTERS = 8'h20;
  localparam int CTRL_DRIVE_BIT = 0;
  localparam int CTRL_SLOW_BIT = 1;
  localparam int CTRL_STROKE_BIT = 2;
  localparam int CTRL_RESTART_BIT = 3;
  localparam logic [15:0] STROKE_SIZE_RESET = 16'h0005;
  typedef struct packed {
    logic pulse;
    logic up;
  } pulse_t;
  typedef struct packed {
    logic signed [15:0] roll;
    logic signed [15:0] pitch;
    logic signed [15:0] yaw;
  } needle_t;
  typedef struct packed {
    logic slow_mode;
    logic drive_request;
  } ctrl_t;
  typedef enum logic [1:0] {PH_IDLE, PH_COMPUTE, PH_COPY, PH_RECOVER} phase_t;
  typedef enum logic [1:0] {ST_OFF, ST_ARMED, ST_DELAY, ST_RUN} stroke_t;
endpackage

/* hw/gimbal_command_interface.sv */
// Purpose: Turns pitch and yaw commands into increment pulse trains and drives the needles.
// Assumes: APB master follows the standard setup and access phases.
// Notes: Soft restart is requested through the control register.
//
// Chosen here: the APB register port and the address map.
module gimbal_command_interface import gimbal_cmd_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int PULSE_CYCLES_P = PULSE_CYCLES
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Converter discretes and pulse trains.
  output logic gimbal_drive_enable_out,
  output logic error_counter_enable_out,
  output logic [1:0] optical_pulse_release_bits_out,
  output pulse_t pitch_train_out,
  output pulse_t yaw_train_out,
  // Needle display.
  output needle_t needle_out,
  output logic needle_load_out
);
  localparam int TW = $clog2(TICK_CYCLES_P + 1);
  localparam int PW = $clog2(PULSE_CYCLES_P + 1);
  localparam logic [TW-1:0] TICK_MAX = TW'(TICK_CYCLES_P - 1);
  localparam logic [PW-1:0] PULSE_MAX = PW'(PULSE_CYCLES_P - 1);

  function automatic logic signed [15:0] needle_scale(input logic signed [15:0] err);
    logic signed [39:0] prod;
    prod = (40'(err) * 40'(REG_FULL_MILLIDEG)) / 40'(NEEDLE_FULL_MILLIDEG);
    if (prod > 40'sh0000007FFF) begin
      return 16'sh7FFF;
    end else if (prod < -40'sh0000008000) begin
      return 16'sh8000;
    end
    return prod[15:0];
  endfunction

  function automatic logic signed [15:0] fly_to(input logic [31:0] att);
    return $signed(att[31:16]) - $signed(att[15:0]);
  endfunction

  logic [TW-1:0] tick_div, next_tick_div;
  logic [PW-1:0] pulse_div, next_pulse_div;
  logic [2:0] samp_cnt, next_samp_cnt;
  logic [4:0] needle_cnt, next_needle_cnt;
  logic needle_init, next_needle_init;
  ctrl_t ctrl, next_ctrl;
  logic signed [15:0] pitch_cmd, next_pitch_cmd, yaw_cmd, next_yaw_cmd;
  logic [31:0] att_p, next_att_p, att_y, next_att_y, att_r, next_att_r;
  logic signed [15:0] stroke_size, next_stroke_size;
  logic signed [15:0] snap_p, next_snap_p, snap_y, next_snap_y;
  logic signed [15:0] temp_p, next_temp_p, temp_y, next_temp_y;
  logic signed [15:0] perm_p, next_perm_p, perm_y, next_perm_y;
  logic signed [15:0] cnt_p, next_cnt_p, cnt_y, next_cnt_y;
  needle_t needle_src, next_needle_src, next_needle_out;
  logic next_needle_load;
  phase_t phase, next_phase, resume_phase, next_resume_phase;
  logic redo_whole, next_redo_whole, holdoff, next_holdoff;
  stroke_t st_state, next_st_state;
  logic [1:0] st_set, next_st_set;
  logic [7:0] st_seg, next_st_seg, st_rev, next_st_rev, st_delay, next_st_delay;
  logic st_up, next_st_up;
  logic next_drive_en, next_ctr_en;
  logic [1:0] next_release;
  pulse_t next_pitch_train, next_yaw_train;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic tick_hit, pulse_hit, samp_hit, needle_hit;
  logic wr, rd, restart_evt, stroke_req, stroke_step;
  logic [2:0] samp_len;

  assign wr = psel_in && penable_in && pready_out && pwrite_in;
  assign rd = psel_in && penable_in && !pready_out && !pwrite_in;
  assign restart_evt = wr && paddr_in == OFF_CTRL && pwdata_in[CTRL_RESTART_BIT];
  assign stroke_req = wr && paddr_in == OFF_CTRL && pwdata_in[CTRL_STROKE_BIT];
  assign tick_hit = tick_div == TICK_MAX;
  assign pulse_hit = pulse_div == PULSE_MAX;
  assign samp_len = ctrl.slow_mode ? SAMPLE_SLOW_TICKS : SAMPLE_FAST_TICKS;
  assign samp_hit = tick_hit && samp_cnt >= samp_len - 3'h1;
  assign needle_hit = !needle_init || (tick_hit && needle_cnt == NEEDLE_TICKS - 5'h01);
  assign stroke_step = st_state == ST_RUN && tick_hit && !restart_evt;

  always_comb begin
    next_tick_div = tick_hit ? '0 : tick_div + 1'b1;
    next_pulse_div = pulse_hit ? '0 : pulse_div + 1'b1;
    next_samp_cnt = samp_hit ? 3'h0 : (tick_hit ? samp_cnt + 3'h1 : samp_cnt);
    next_needle_cnt = needle_hit ? 5'h00 : (tick_hit ? needle_cnt + 5'h01 : needle_cnt);
    next_needle_init = 1'b1;
    next_ctrl = ctrl;
    next_pitch_cmd = pitch_cmd;
    next_yaw_cmd = yaw_cmd;
    next_att_p = att_p;
    next_att_y = att_y;
    next_att_r = att_r;
    next_stroke_size = stroke_size;
    next_snap_p = snap_p;
    next_snap_y = snap_y;
    next_temp_p = temp_p;
    next_temp_y = temp_y;
    next_perm_p = perm_p;
    next_perm_y = perm_y;
    next_cnt_p = cnt_p;
    next_cnt_y = cnt_y;
    next_needle_src = needle_src;
    next_needle_out = needle_out;
    next_needle_load = 1'b0;
    next_phase = phase;
    next_resume_phase = resume_phase;
    next_redo_whole = redo_whole;
    next_holdoff = holdoff;
    next_st_state = st_state;
    next_st_set = st_set;
    next_st_seg = st_seg;
    next_st_rev = st_rev;
    next_st_delay = st_delay;
    next_st_up = st_up;
    next_drive_en = ctrl.drive_request;
    next_ctr_en = ctrl.drive_request;
    next_pitch_train = '0;
    next_yaw_train = '0;
    next_pready = psel_in && penable_in && !pready_out;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    if (psel_in && penable_in && !pready_out) begin
      unique case (paddr_in)
        OFF_CTRL: next_prdata = {30'h00000000, ctrl.slow_mode, ctrl.drive_request};
        OFF_PITCH_CMD: next_prdata = {16'h0000, pitch_cmd};
        OFF_YAW_CMD: next_prdata = {16'h0000, yaw_cmd};
        OFF_PITCH_ATT: next_prdata = att_p;
        OFF_YAW_ATT: next_prdata = att_y;
        OFF_ROLL_ATT: next_prdata = att_r;
        OFF_STROKE_SIZE: next_prdata = {16'h0000, stroke_size};
        OFF_STATUS: next_prdata = {26'h0000000, redo_whole, st_state == ST_ARMED || st_state == ST_DELAY,
                                   st_state == ST_RUN, holdoff, error_counter_enable_out,
                                   gimbal_drive_enable_out};
        OFF_COUNTERS: next_prdata = {cnt_y, cnt_p};
        default: next_pslverr = 1'b1;
      endcase
      if (!rd) begin
        next_prdata = 32'h00000000;
      end
    end
    if (wr) begin
      unique case (paddr_in)
        OFF_CTRL: next_ctrl = '{slow_mode: pwdata_in[CTRL_SLOW_BIT], drive_request: pwdata_in[CTRL_DRIVE_BIT]};
        OFF_PITCH_CMD: next_pitch_cmd = pwdata_in[15:0];
        OFF_YAW_CMD: next_yaw_cmd = pwdata_in[15:0];
        OFF_PITCH_ATT: next_att_p = pwdata_in;
        OFF_YAW_ATT: next_att_y = pwdata_in;
        OFF_ROLL_ATT: next_att_r = pwdata_in;
        OFF_STROKE_SIZE: next_stroke_size = pwdata_in[15:0];
        default: ;
      endcase
    end
    if (needle_hit) begin
      next_needle_load = 1'b1;
      next_needle_out = '{roll: needle_scale(needle_src.roll), pitch: needle_scale(needle_src.pitch),
                          yaw: needle_scale(needle_src.yaw)};
    end
    next_release = {error_counter_enable_out && cnt_y != 16'sh0000,
                    error_counter_enable_out && cnt_p != 16'sh0000};
    if (pulse_hit && optical_pulse_release_bits_out[0] && cnt_p != 16'sh0000) begin
      next_pitch_train = '{pulse: 1'b1, up: !cnt_p[15]};
      next_cnt_p = cnt_p[15] ? cnt_p + 16'sh0001 : cnt_p - 16'sh0001;
    end
    if (pulse_hit && optical_pulse_release_bits_out[1] && cnt_y != 16'sh0000) begin
      next_yaw_train = '{pulse: 1'b1, up: !cnt_y[15]};
      next_cnt_y = cnt_y[15] ? cnt_y + 16'sh0001 : cnt_y - 16'sh0001;
    end
    if (samp_hit) begin
      next_needle_src = '{roll: fly_to(att_r), pitch: fly_to(att_p), yaw: fly_to(att_y)};
    end
    unique case (phase)
      PH_IDLE: begin
        if (samp_hit && holdoff) begin
          next_holdoff = 1'b0;
        end else if (samp_hit) begin
          next_snap_p = pitch_cmd;
          next_snap_y = yaw_cmd;
          next_phase = PH_COMPUTE;
        end
      end
      PH_COMPUTE: begin
        next_temp_p = snap_p;
        next_temp_y = snap_y;
        next_redo_whole = 1'b0;
        next_phase = PH_COPY;
      end
      PH_COPY: begin
        next_cnt_p = next_cnt_p + (temp_p - perm_p);
        next_cnt_y = next_cnt_y + (temp_y - perm_y);
        next_perm_p = temp_p;
        next_perm_y = temp_y;
        next_phase = PH_IDLE;
      end
      PH_RECOVER: begin
        next_cnt_p = perm_p;
        next_cnt_y = perm_y;
        next_holdoff = 1'b1;
        next_tick_div = '0;
        next_samp_cnt = 3'h0;
        next_phase = resume_phase;
      end
    endcase
    unique case (st_state)
      ST_OFF: begin
        if (stroke_req) begin
          next_st_state = ctrl.slow_mode ? ST_RUN : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (ctrl.slow_mode) begin
          next_st_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (tick_hit) begin
          next_st_delay = st_delay + 8'h01;
        end
        if (tick_hit && st_delay == STROKE_DELAY_TICKS - 8'h01) begin
          next_st_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stroke_step) begin
          next_cnt_p = st_up ? next_cnt_p + stroke_size : next_cnt_p - stroke_size;
          next_st_seg = st_seg - 8'h01;
          if (st_seg == 8'h01 && st_rev != 8'h00) begin
            next_st_up = !st_up;
            next_st_rev = st_rev - 8'h01;
            next_st_seg = STROKE_HALF_AMP[st_set];
          end else if (st_seg == 8'h01) begin
            next_st_set = st_set + 2'h1;
            next_st_seg = STROKE_HALF_AMP[2'(st_set + 2'h1)];
            next_st_rev = STROKE_REVERSALS[2'(st_set + 2'h1)];
            next_st_up = !st_up;
            if ({1'b0, st_set} == STROKE_FREQS - 3'h1) begin
              next_st_state = ST_OFF;
            end
          end
        end
      end
    endcase
    if (st_state != ST_RUN && next_st_state == ST_RUN) begin
      next_st_set = 2'h0;
      next_st_seg = STROKE_HALF_AMP[0];
      next_st_rev = STROKE_REVERSALS[0];
      next_st_up = 1'b1;
    end
    if (st_state != ST_DELAY) begin
      next_st_delay = 8'h00;
    end
    if (restart_evt) begin
      next_drive_en = 1'b0;
      next_ctr_en = 1'b0;
      next_release = 2'b00;
      next_pitch_train = '0;
      next_yaw_train = '0;
      next_cnt_p = 16'sh0000;
      next_cnt_y = 16'sh0000;
      next_st_state = ST_OFF;
      next_phase = PH_RECOVER;
      next_resume_phase = phase == PH_COPY ? PH_COPY : PH_IDLE;
      next_redo_whole = 1'b0;
      if (phase == PH_COMPUTE) begin
        next_redo_whole = snap_p != pitch_cmd || snap_y != yaw_cmd;
        next_resume_phase = next_redo_whole ? PH_IDLE : PH_COMPUTE;
      end
      if (phase == PH_RECOVER) begin
        next_resume_phase = resume_phase;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tick_div <= '0;
      pulse_div <= '0;
      samp_cnt <= 3'h0;
      needle_cnt <= 5'h00;
      needle_init <= 1'b0;
      ctrl <= '0;
      pitch_cmd <= 16'sh0000;
      yaw_cmd <= 16'sh0000;
      att_p <= 32'h00000000;
      att_y <= 32'h00000000;
      att_r <= 32'h00000000;
      stroke_size <= STROKE_SIZE_RESET;
      snap_p <= 16'sh0000;
      snap_y <= 16'sh0000;
      temp_p <= 16'sh0000;
      temp_y <= 16'sh0000;
      perm_p <= 16'sh0000;
      perm_y <= 16'sh0000;
      cnt_p <= 16'sh0000;
      cnt_y <= 16'sh0000;
      needle_src <= '0;
      needle_out <= '0;
      needle_load_out <= 1'b0;
      phase <= PH_IDLE;
      resume_phase <= PH_IDLE;
      redo_whole <= 1'b0;
      holdoff <= 1'b0;
      st_state <= ST_OFF;
      st_set <= 2'h0;
      st_seg <= 8'h00;
      st_rev <= 8'h00;
      st_delay <= 8'h00;
      st_up <= 1'b1;
      gimbal_drive_enable_out <= 1'b0;
      error_counter_enable_out <= 1'b0;
      optical_pulse_release_bits_out <= 2'b00;
      pitch_train_out <= '0;
      yaw_train_out <= '0;
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      tick_div <= next_tick_div;
      pulse_div <= next_pulse_div;
      samp_cnt <= next_samp_cnt;
      needle_cnt <= next_needle_cnt;
      needle_init <= next_needle_init;
      ctrl <= next_ctrl;
      pitch_cmd <= next_pitch_cmd;
      yaw_cmd <= next_yaw_cmd;
      att_p <= next_att_p;
      att_y <= next_att_y;
      att_r <= next_att_r;
      stroke_size <= next_stroke_size;
      snap_p <= next_snap_p;
      snap_y <= next_snap_y;
      temp_p <= next_temp_p;
      temp_y <= next_temp_y;
      perm_p <= next_perm_p;
      perm_y <= next_perm_y;
      cnt_p <= next_cnt_p;
      cnt_y <= next_cnt_y;
      needle_src <= next_needle_src;
      needle_out <= next_needle_out;
      needle_load_out <= next_needle_load;
      phase <= next_phase;
      resume_phase <= next_resume_phase;
      redo_whole <= next_redo_whole;
      holdoff <= next_holdoff;
      st_state <= next_st_state;
      st_set <= next_st_set;
      st_seg <= next_st_seg;
      st_rev <= next_st_rev;
      st_delay <= next_st_delay;
      st_up <= next_st_up;
      gimbal_drive_enable_out <= next_drive_en;
      error_counter_enable_out <= next_ctr_en;
      optical_pulse_release_bits_out <= next_release;
      pitch_train_out <= next_pitch_train;
      yaw_train_out <= next_yaw_train;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  logic [PW-1:0] yaw_gap, next_yaw_gap;
  always_comb begin
    next_yaw_gap = yaw_gap == PULSE_MAX ? PULSE_MAX : yaw_gap + 1'b1;
    if (yaw_train_out.pulse) begin
      next_yaw_gap = '0;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      yaw_gap <= PULSE_MAX;
    end else begin
      yaw_gap <= next_yaw_gap;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_restart;
    restart_evt;
  endsequence
  sequence s_recover;
    phase == PH_RECOVER ##1 (cnt_p == $past(perm_p) && cnt_y == $past(perm_y));
  endsequence

  a_restart_clears: assert property (s_restart |=> !gimbal_drive_enable_out && !error_counter_enable_out)
    else $error("enables not cleared by restart");
  a_restart_reload: assert property (s_restart |=> s_recover)
    else $error("counters not reloaded after restart");
  a_drive_request: assert property (gimbal_drive_enable_out |-> $past(ctrl.drive_request))
    else $error("drive enable without request");
  a_pulse_release: assert property (pitch_train_out.pulse |-> $past(optical_pulse_release_bits_out[0]))
    else $error("pitch pulse without release bit");
  a_pulse_dir: assert property (pitch_train_out.pulse && !$past(restart_evt) && $past(phase) == PH_IDLE
    && $past(st_state) != ST_RUN |-> pitch_train_out.up == !$past(cnt_p[15]))
    else $error("pitch pulse direction wrong");
  a_pulse_gap: assert property (yaw_train_out.pulse |-> yaw_gap == PULSE_MAX)
    else $error("yaw pulses too close");
  a_stroke_abort: assert property (s_restart |=> st_state == ST_OFF)
    else $error("stroke survived restart");
  a_holdoff_wait: assert property (holdoff && phase == PH_IDLE |=> phase != PH_COMPUTE)
    else $error("compute during holdoff");
  a_needle_load: assert property (needle_load_out |-> needle_out.pitch == needle_scale($past(needle_src.pitch)))
    else $error("needle loaded with wrong value");
  a_copy_perm: assert property (phase == PH_COPY && !restart_evt |=> perm_p == $past(temp_p))
    else $error("copy phase did not update storage");
  a_stroke_arm: assert property (st_state == ST_OFF && stroke_req && !ctrl.slow_mode |=> st_state == ST_ARMED)
    else $error("stroke did not arm in fast mode");
endmodule

/* tb/converter_model.sv */
// Purpose: Behavioural angle converter error counters fed by the pulse trains.
// Assumes: Pulses are one clock wide.
// Notes: Counters clear while the counter enable is low.
module converter_model import gimbal_cmd_pkg::*; (
  // Discretes and trains.
  input wire logic clock_in,
  input wire logic drive_en_in,
  input wire logic count_en_in,
  input wire pulse_t pitch_in,
  input wire pulse_t yaw_in,
  // Actuator drive levels.
  output logic signed [15:0] pitch_drive_out,
  output logic signed [15:0] yaw_drive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] pitch_count = 16'sh0000;
  logic signed [15:0] yaw_count = 16'sh0000;
  always @(posedge clock_in) begin
    if (count_en_in !== 1'b1) begin
      pitch_count <= 16'sh0000;
      yaw_count <= 16'sh0000;
    end else begin
      if (pitch_in.pulse) pitch_count <= pitch_count + (pitch_in.up ? 16'sh0001 : 16'shFFFF);
      if (yaw_in.pulse) yaw_count <= yaw_count + (yaw_in.up ? 16'sh0001 : 16'shFFFF);
    end
  end
  assign pitch_drive_out = drive_en_in ? pitch_count : 16'sh0000;
  assign yaw_drive_out = drive_en_in ? yaw_count : 16'sh0000;
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the gimbal command interface.
// Assumes: Shortened tick of 20 cycles and pulse spacing of 4 cycles.
// Notes: Register cases run from a table; restart and stroke cases follow.
module tb_top;
  import gimbal_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
    logic err;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, drv_en, cnt_en, needle_load;
  logic [1:0] rel_bits;
  pulse_t pitch_tr, yaw_tr;
  needle_t needle;
  logic signed [15:0] pitch_lvl, yaw_lvl;
  logic arm = 1'b0;
  logic saw_off = 1'b0;
  int num_errors = 0;
  int checked = 0;
  row_t rows [8];
  always #20 clk = ~clk;
  always @(posedge clk) if (arm && drv_en !== 1'b1) saw_off <= 1'b1;
  gimbal_command_interface #(.TICK_CYCLES_P(20), .PULSE_CYCLES_P(4)) u_gimbal_command_interface (
    .clock_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .gimbal_drive_enable_out(drv_en), .error_counter_enable_out(cnt_en),
    .optical_pulse_release_bits_out(rel_bits), .pitch_train_out(pitch_tr), .yaw_train_out(yaw_tr),
    .needle_out(needle), .needle_load_out(needle_load));
  converter_model u_converter_model (.clock_in(clk), .drive_en_in(drv_en), .count_en_in(cnt_en),
    .pitch_in(pitch_tr), .yaw_in(yaw_tr), .pitch_drive_out(pitch_lvl), .yaw_drive_out(yaw_lvl));
  task automatic end_sim();
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_load(output logic [31:0] n);
    n = 32'h0;
    do begin
      @(posedge clk);
      n++;
    end while (needle_load !== 1'b1 && n < 32'h3E8);
    if (n >= 32'h3E8) begin
      num_errors++;
      end_sim();
    end
  endtask
  initial begin
    logic [31:0] rd, n;
    logic er;
    rows = '{'{1'b0, OFF_STROKE_SIZE, 32'h0, 32'hFFFF, 32'h5, 1'b0}, '{1'b0, 8'h24, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1},
             '{1'b1, OFF_STATUS, 32'hFF, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_STATUS, 32'h0, 32'h3, 32'h0, 1'b0},
             '{1'b1, OFF_STROKE_SIZE, 32'h7, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_STROKE_SIZE, 32'h0, 32'hFFFF, 32'h7, 1'b0},
             '{1'b1, OFF_CTRL, 32'h1, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_STATUS, 32'h0, 32'h3, 32'h3, 1'b0}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b1, OFF_PITCH_ATT, 32'h01000080, rd, er);
    apb(1'b1, OFF_ROLL_ATT, 32'h40000000, rd, er);
    wait_load(n);
    wait_load(n);
    chk("needle period", 32'(NEEDLE_TICKS) * 32'h14, n);
    chk("pitch needle", 32'h555, 32'(needle.pitch));
    chk("roll needle", 32'h7FFF, 32'(needle.roll));
    for (int i = 0; i < 8; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
      chk("apb data", rows[i].e, rd & rows[i].m);
      chk("apb error", {31'h0, rows[i].err}, {31'h0, er});
    end
    apb(1'b1, OFF_PITCH_CMD, 32'h3, rd, er);
    apb(1'b1, OFF_YAW_CMD, 32'hFFFE, rd, er);
    arm <= 1'b1;
    repeat (200) @(posedge clk);
    chk("yaw level", 32'hFFFFFFFE, 32'(yaw_lvl));
    apb(1'b1, OFF_PITCH_CMD, 32'h5, rd, er);
    repeat (200) @(posedge clk);
    chk("pitch level", 32'h5, 32'(pitch_lvl));
    chk("release bits", 32'h0, {30'h0, rel_bits});
    apb(1'b1, OFF_CTRL, 32'h9, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("holdoff", 32'h4, rd & 32'h4);
    apb(1'b1, OFF_PITCH_CMD, 32'h9, rd, er);
    repeat (60) @(posedge clk);
    chk("pitch held", 32'h5, 32'(pitch_lvl));
    repeat (140) @(posedge clk);
    chk("drive dropped", 32'h1, {31'h0, saw_off});
    chk("pitch restored", 32'h9, 32'(pitch_lvl));
    chk("yaw restored", 32'hFFFFFFFE, 32'(yaw_lvl));
    apb(1'b1, OFF_CTRL, 32'h7, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("stroke armed", 32'h10, rd & 32'h18);
    repeat (3900) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("stroke delayed", 32'h10, rd & 32'h18);
    repeat (100) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("stroke run", 32'h8, rd & 32'h18);
    repeat (200) @(posedge clk);
    chk("yaw unstroked", 32'hFFFFFFFE, 32'(yaw_lvl));
    apb(1'b1, OFF_CTRL, 32'h9, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("stroke stopped", 32'h0, rd & 32'h8);
    apb(1'b1, OFF_CTRL, 32'h3, rd, er);
    apb(1'b1, OFF_CTRL, 32'h7, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("stroke rerun", 32'h8, rd & 32'h18);
    rst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk("reset drive", 32'h0, {31'h0, drv_en});
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("init needle load", 32'h1, {31'h0, needle_load});
    end_sim();
  end
endmodule
